// >>> hdl/block_gating_pkg.sv
package block_gating_pkg;
  // register addresses (byte addresses of the 8-bit registers)
  localparam logic [15:0] SERIAL_PORT_DISABLE_ADDR = 16'hF02A;
  localparam logic [15:0] CONVERTER_DISABLE_ADDR   = 16'hF02C;
  localparam logic [15:0] TIMER_DISABLE_ADDR       = 16'hF02E;
  localparam logic [15:0] PWM_DISABLE_ADDR         = 16'hF02F;
  // reset value of every gating register
  localparam logic [7:0]  GATING_RESET             = 8'h00;
  // field positions, serial port register
  localparam int SYNC_SERIAL_OFF_BIT = 0;
  localparam int FIRST_UART_OFF_BIT  = 2;
  localparam int SECOND_UART_OFF_BIT = 3;
  localparam int I2C_SLAVE_OFF_BIT   = 6;
  localparam int I2C_MASTER_OFF_BIT  = 7;
  // field position, converter register
  localparam int ADC_OFF_BIT         = 0;
  // field positions, timer register
  localparam int TIMER_EIGHT_OFF_BIT = 0;
  localparam int TIMER_NINE_OFF_BIT  = 1;
  localparam int TIMER_A_OFF_BIT     = 2;
  localparam int TIMER_B_OFF_BIT     = 3;
  localparam int TIMER_E_OFF_BIT     = 6;
  localparam int TIMER_F_OFF_BIT     = 7;
  // field positions, pwm register
  localparam int PWM_C_OFF_BIT       = 0;
  localparam int PWM_D_OFF_BIT       = 1;
  localparam int PWM_E_OFF_BIT       = 2;
  localparam int PWM_F_OFF_BIT       = 3;
  // number of gated peripherals
  localparam int PERIPH_COUNT        = 16;
  // peripheral index on the gate vector
  localparam int IDX_SYNC_SERIAL = 0;
  localparam int IDX_FIRST_UART  = 1;
  localparam int IDX_SECOND_UART = 2;
  localparam int IDX_I2C_SLAVE   = 3;
  localparam int IDX_I2C_MASTER  = 4;
  localparam int IDX_ADC         = 5;
  localparam int IDX_TIMER_EIGHT = 6;
  localparam int IDX_TIMER_NINE  = 7;
  localparam int IDX_TIMER_A     = 8;
  localparam int IDX_TIMER_B     = 9;
  localparam int IDX_TIMER_E     = 10;
  localparam int IDX_TIMER_F     = 11;
  localparam int IDX_PWM_C       = 12;
  localparam int IDX_PWM_D       = 13;
  localparam int IDX_PWM_E       = 14;
  localparam int IDX_PWM_F       = 15;
endpackage

// >>> hdl/periph_gate.sv
`timescale 1ns/1ps
// one peripheral's gate: reset, clock enable, write block and read substitution
module periph_gate (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       off,           // gating bit
  input  wire logic       wr_in,         // write strobe from software
  input  wire logic [7:0] rd_in,         // peripheral read data
  input  wire logic [7:0] rd_init,       // peripheral register initial value
  output logic            periph_reset,  // holds peripheral in reset
  output logic            clk_en,        // clock enable for glitch-free gate
  output logic            wr_out,        // filtered write strobe
  output logic [7:0]      rd_out         // read data seen by software
);
  // reset and clock stop are registered so they come straight from flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      periph_reset <= 1'b1;
      clk_en       <= 1'b0;
    end else begin
      periph_reset <= off;
      clk_en       <= ~off;
    end
  end

  // writes die and reads show initial value while off
  always_comb begin
    wr_out = wr_in & ~off;
    rd_out = off ? rd_init : rd_in;
  end
endmodule // periph_gate

// >>> hdl/peripheral_block_gating.sv
`timescale 1ns/1ps
// Contract
// - serial reg bit 0 disables sync serial
// - serial reg bit 2 disables first uart
// - serial reg bit 3 disables second uart
// - serial reg bit 6 disables i2c slave
// - serial reg bit 7 disables i2c master
// - converter reg bit 0 resets, stops adc
// - timer reg bits 0-3 disable timers 8,9,A,B
// - timer reg bits 6,7 disable timers E,F
// - pwm reg bits 0-3 disable pwm C-F
// - set bit holds peripheral in reset
// - set bit stops peripheral clock
// - set bit blocks peripheral register writes
// - set bit makes reads return initial values
// - registers 8-bit, read/write, reset to zero
// - system reset initializes all gating registers
module peripheral_block_gating (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [15:0] reg_addr,        // register address
  input  wire logic [7:0]  reg_wdata,       // write data
  input  wire logic        reg_write,       // write strobe
  input  wire logic        reg_read,        // read strobe
  output logic      [7:0]  reg_rdata,       // read data, cycle after strobe
  input  wire logic [15:0] periph_wr,       // per-peripheral write strobes
  input  wire logic [127:0] periph_rdata,   // per-peripheral read data, 8 bits each
  input  wire logic [127:0] periph_init,    // per-peripheral initial values
  output logic      [15:0] periph_reset,    // held reset per peripheral
  output logic      [15:0] periph_clk_en,   // clock enable per peripheral
  output logic      [15:0] periph_wr_gated, // filtered write strobes
  output logic      [127:0] periph_rdata_gated // read data for software
);
  // gating registers
  logic [7:0]  serial_port_disable;  // sync serial, uarts, i2c
  logic [7:0]  converter_disable;    // a/d converter
  logic [7:0]  timer_disable;        // timers
  logic [7:0]  pwm_disable;          // pwm channels
  logic [15:0] off;                  // per-peripheral disable vector
  logic [15:0] wr_comb;              // unregistered filtered writes
  logic [127:0] rd_comb;             // unregistered substituted reads

  // address match helper, used for write and read decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    return a == r;
  endfunction

  // register writes; all bits store, spare ones included
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serial_port_disable <= block_gating_pkg::GATING_RESET;
      converter_disable   <= block_gating_pkg::GATING_RESET;
      timer_disable       <= block_gating_pkg::GATING_RESET;
      pwm_disable         <= block_gating_pkg::GATING_RESET;
    end else if (reg_write) begin
      // full byte stored, spare bits read back only
      if (hit(reg_addr, block_gating_pkg::SERIAL_PORT_DISABLE_ADDR)) begin
        serial_port_disable <= reg_wdata;
      end
      if (hit(reg_addr, block_gating_pkg::CONVERTER_DISABLE_ADDR)) begin
        converter_disable <= reg_wdata;
      end
      if (hit(reg_addr, block_gating_pkg::TIMER_DISABLE_ADDR)) begin
        timer_disable <= reg_wdata;
      end
      if (hit(reg_addr, block_gating_pkg::PWM_DISABLE_ADDR)) begin
        pwm_disable <= reg_wdata;
      end
    end
  end

  // read port: data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (hit(reg_addr, block_gating_pkg::SERIAL_PORT_DISABLE_ADDR)) begin
        reg_rdata <= serial_port_disable;
      end else if (hit(reg_addr, block_gating_pkg::CONVERTER_DISABLE_ADDR)) begin
        reg_rdata <= converter_disable;
      end else if (hit(reg_addr, block_gating_pkg::TIMER_DISABLE_ADDR)) begin
        reg_rdata <= timer_disable;
      end else if (hit(reg_addr, block_gating_pkg::PWM_DISABLE_ADDR)) begin
        reg_rdata <= pwm_disable;
      end else begin
        // unmapped addresses read zero
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // map documented bits onto the peripheral vector; spare bits unused
  always_comb begin
    off = '0;
    off[block_gating_pkg::IDX_SYNC_SERIAL] =
      serial_port_disable[block_gating_pkg::SYNC_SERIAL_OFF_BIT];
    off[block_gating_pkg::IDX_FIRST_UART] =
      serial_port_disable[block_gating_pkg::FIRST_UART_OFF_BIT];
    off[block_gating_pkg::IDX_SECOND_UART] =
      serial_port_disable[block_gating_pkg::SECOND_UART_OFF_BIT];
    off[block_gating_pkg::IDX_I2C_SLAVE] =
      serial_port_disable[block_gating_pkg::I2C_SLAVE_OFF_BIT];
    off[block_gating_pkg::IDX_I2C_MASTER] =
      serial_port_disable[block_gating_pkg::I2C_MASTER_OFF_BIT];
    off[block_gating_pkg::IDX_ADC] =
      converter_disable[block_gating_pkg::ADC_OFF_BIT];
    off[block_gating_pkg::IDX_TIMER_EIGHT] =
      timer_disable[block_gating_pkg::TIMER_EIGHT_OFF_BIT];
    off[block_gating_pkg::IDX_TIMER_NINE] =
      timer_disable[block_gating_pkg::TIMER_NINE_OFF_BIT];
    off[block_gating_pkg::IDX_TIMER_A] =
      timer_disable[block_gating_pkg::TIMER_A_OFF_BIT];
    off[block_gating_pkg::IDX_TIMER_B] =
      timer_disable[block_gating_pkg::TIMER_B_OFF_BIT];
    off[block_gating_pkg::IDX_TIMER_E] =
      timer_disable[block_gating_pkg::TIMER_E_OFF_BIT];
    off[block_gating_pkg::IDX_TIMER_F] =
      timer_disable[block_gating_pkg::TIMER_F_OFF_BIT];
    off[block_gating_pkg::IDX_PWM_C] = pwm_disable[block_gating_pkg::PWM_C_OFF_BIT];
    off[block_gating_pkg::IDX_PWM_D] = pwm_disable[block_gating_pkg::PWM_D_OFF_BIT];
    off[block_gating_pkg::IDX_PWM_E] = pwm_disable[block_gating_pkg::PWM_E_OFF_BIT];
    off[block_gating_pkg::IDX_PWM_F] = pwm_disable[block_gating_pkg::PWM_F_OFF_BIT];
  end

  // one gate per peripheral; reset and clock stop registered inside
  for (genvar g = 0; g < block_gating_pkg::PERIPH_COUNT; g++) begin : gate
    periph_gate u_gate (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .off          (off[g]),
      .wr_in        (periph_wr[g]),
      .rd_in        (periph_rdata[g*8 +: 8]),
      .rd_init      (periph_init[g*8 +: 8]),
      .periph_reset (periph_reset[g]),
      .clk_en       (periph_clk_en[g]),
      .wr_out       (wr_comb[g]),
      .rd_out       (rd_comb[g*8 +: 8])
    );
  end

  // gated bus paths registered so top outputs come from flops;
  // costs one cycle of latency on the peripheral register path
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      periph_wr_gated    <= '0;
      periph_rdata_gated <= '0;
    end else begin
      periph_wr_gated    <= wr_comb;
      periph_rdata_gated <= rd_comb;
    end
  end

  // software must clear a bit before use; reset stays while bit is set
  AST_UART_RESET_HELD: assert property (@(posedge clk_sys) disable iff (reset)
    serial_port_disable[block_gating_pkg::FIRST_UART_OFF_BIT]
      |=> periph_reset[block_gating_pkg::IDX_FIRST_UART])
    else $error("first uart not held in reset");

  AST_CLOCK_STOPPED: assert property (@(posedge clk_sys) disable iff (reset)
    timer_disable[block_gating_pkg::TIMER_F_OFF_BIT]
      |=> !periph_clk_en[block_gating_pkg::IDX_TIMER_F])
    else $error("timer f clock not stopped");

  AST_WRITE_BLOCKED: assert property (@(posedge clk_sys) disable iff (reset)
    off[block_gating_pkg::IDX_ADC] |=> !periph_wr_gated[block_gating_pkg::IDX_ADC])
    else $error("write passed to disabled converter");

  AST_WRITE_PASSED: assert property (@(posedge clk_sys) disable iff (reset)
    !off[0] && periph_wr[0] |=> periph_wr_gated[0])
    else $error("write to enabled serial port lost");

  AST_READ_INIT: assert property (@(posedge clk_sys) disable iff (reset)
    off[block_gating_pkg::IDX_PWM_C] |=>
      periph_rdata_gated[8*block_gating_pkg::IDX_PWM_C +: 8] ==
      $past(periph_init[8*block_gating_pkg::IDX_PWM_C +: 8]))
    else $error("disabled pwm read not initial value");

  // named steps of a timer register access, used by the readback check
  sequence timer_reg_write;
    reg_write && hit(reg_addr, block_gating_pkg::TIMER_DISABLE_ADDR);
  endsequence

  // read strobe aimed at the timer register
  sequence timer_reg_read;
    reg_read && hit(reg_addr, block_gating_pkg::TIMER_DISABLE_ADDR);
  endsequence

  // back-to-back write then read must return the byte just stored
  AST_REG_READBACK: assert property (@(posedge clk_sys) disable iff (reset)
    timer_reg_write ##1 timer_reg_read
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("timer register readback mismatch");

  AST_SPARE_NO_EFFECT: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(serial_port_disable) && ($past(serial_port_disable) ^ serial_port_disable)
      == 8'h32 |-> $stable(off))
    else $error("spare bit changed a peripheral gate");

  AST_RESET_CLEARS: assert property (@(posedge clk_sys)
    $past(reset) |-> serial_port_disable == 8'h00 && pwm_disable == 8'h00)
    else $error("gating register not cleared by reset");

  AST_MASTER_SLAVE: assert property (@(posedge clk_sys) disable iff (reset)
    off[block_gating_pkg::IDX_I2C_MASTER] == serial_port_disable[7] &&
    off[block_gating_pkg::IDX_I2C_SLAVE] == serial_port_disable[6])
    else $error("i2c gate mapping wrong");

  AST_UART_TWO: assert property (@(posedge clk_sys) disable iff (reset)
    !serial_port_disable[3] ##1 !serial_port_disable[3]
      |-> !periph_reset[block_gating_pkg::IDX_SECOND_UART])
    else $error("second uart reset while enabled");

  // true for any of the four gating register addresses
  function automatic logic mapped(input logic [15:0] a);
    return hit(a, block_gating_pkg::SERIAL_PORT_DISABLE_ADDR) ||
           hit(a, block_gating_pkg::CONVERTER_DISABLE_ADDR) ||
           hit(a, block_gating_pkg::TIMER_DISABLE_ADDR) ||
           hit(a, block_gating_pkg::PWM_DISABLE_ADDR);
  endfunction

  // read data must fall back to zero when no read was taken;
  // software that samples late would otherwise see stale bytes
  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not idle after strobe");

  // unmapped reads answer zero and never alias a gating register
  AST_RDATA_UNMAPPED: assert property (@(posedge clk_sys) disable iff (reset)
    reg_read && !mapped(reg_addr) |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");

  // during system reset every gate shuts and the gated write path is quiet
  AST_RESET_OUTPUTS: assert property (@(posedge clk_sys)
    reset |=> (&periph_reset) && periph_clk_en == 16'h0000 &&
      periph_wr_gated == 16'h0000)
    else $error("gate outputs wrong during reset");

  // converter spare bits must not move any gate
  AST_SPARE_CONVERTER: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(converter_disable) &&
      (($past(converter_disable) ^ converter_disable) & 8'h01) == 8'h00
      |-> $stable(off))
    else $error("converter spare bit changed a gate");

  // timer spare bits 4 and 5 must not move any gate
  AST_SPARE_TIMER: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(timer_disable) &&
      (($past(timer_disable) ^ timer_disable) & 8'hCF) == 8'h00
      |-> $stable(off))
    else $error("timer spare bit changed a gate");

  // pwm upper nibble is spare and must not move any gate
  AST_SPARE_PWM: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(pwm_disable) &&
      (($past(pwm_disable) ^ pwm_disable) & 8'h0F) == 8'h00
      |-> $stable(off))
    else $error("pwm spare bit changed a gate");

  // per-peripheral checks, one set for every gate on the vector;
  // each looks one cycle back because every gate output is registered
  for (genvar k = 0; k < block_gating_pkg::PERIPH_COUNT; k++) begin : gate_check
    // disabled peripheral sits in reset with its clock stopped
    AST_GATE_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
      off[k] |=> periph_reset[k] && !periph_clk_en[k])
      else $error("disabled peripheral still running");

    // enabled peripheral leaves reset and gets its clock back
    AST_GATE_RELEASE: assert property (@(posedge clk_sys) disable iff (reset)
      !off[k] |=> !periph_reset[k] && periph_clk_en[k])
      else $error("enabled peripheral still held");

    // a write reaches the peripheral only while its gate is open
    AST_GATE_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
      periph_wr[k] |=> periph_wr_gated[k] == !$past(off[k]))
      else $error("gated write strobe wrong");

    // no write strobe appears without a request
    AST_GATE_NO_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
      !periph_wr[k] |=> !periph_wr_gated[k])
      else $error("spurious gated write strobe");

    // read path shows the initial value while shut, live data otherwise
    AST_GATE_READ: assert property (@(posedge clk_sys) disable iff (reset)
      1'b1 |=> periph_rdata_gated[8*k +: 8] == ($past(off[k]) ?
        $past(periph_init[8*k +: 8]) : $past(periph_rdata[8*k +: 8])))
      else $error("gated read data wrong");
  end
endmodule // peripheral_block_gating

// >>> verification/gated_periph_model.sv
`timescale 1ns/1ps
// sixteen stand-in peripherals, one byte register each
module gated_periph_model (
  input  wire logic [15:0]  periph_reset,
  input  wire logic [15:0]  periph_clk_en,
  input  wire logic [15:0]  periph_wr_gated,
  input  wire logic [7:0]   wdata,
  input  wire logic         clk_sys,
  output logic      [127:0] periph_rdata,
  output logic      [127:0] periph_init
);
  // distinct initial values so a swapped byte lane shows up
  always_comb begin
    for (int g = 0; g < 16; g++) periph_init[8*g +: 8] = 8'hA0 + 8'(g);
  end
  // held at init in reset, frozen while its clock is stopped
  always_ff @(posedge clk_sys) begin
    for (int g = 0; g < 16; g++) begin
      if (periph_reset[g]) periph_rdata[8*g +: 8] <= 8'hA0 + 8'(g);
      else if (periph_clk_en[g] && periph_wr_gated[g]) periph_rdata[8*g +: 8] <= wdata;
    end
  end
endmodule // gated_periph_model

// >>> verification/peripheral_block_gating_bench.sv
`timescale 1ns/1ps
// self-checking bench for the gating registers
module peripheral_block_gating_bench;
  logic         clk_sys, reset;          // 50 MHz clock, sync reset
  logic [15:0]  reg_addr;                // bus address
  logic [7:0]   reg_wdata, reg_rdata;    // bus data
  logic         reg_write, reg_read;     // bus strobes
  logic [15:0]  periph_wr;               // peripheral-side strobes
  logic [7:0]   wdata;                   // byte the model stores
  logic [127:0] periph_rdata, periph_init, periph_rdata_gated;
  logic [15:0]  periph_reset, periph_clk_en, periph_wr_gated;
  int           n_errors, samples_checked;
  // register per index and bit per peripheral, in gate-vector order
  logic [15:0]  ra [4] = '{block_gating_pkg::SERIAL_PORT_DISABLE_ADDR,
    block_gating_pkg::CONVERTER_DISABLE_ADDR, block_gating_pkg::TIMER_DISABLE_ADDR,
    block_gating_pkg::PWM_DISABLE_ADDR};
  int           bpos [16] = '{0, 2, 3, 6, 7, 0, 0, 1, 2, 3, 6, 7, 0, 1, 2, 3};
  // unassigned bits: stored but must gate nothing
  logic [7:0]   spare [4] = '{8'h32, 8'hFE, 8'h30, 8'hF0};

  peripheral_block_gating DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .periph_wr(periph_wr), .periph_rdata(periph_rdata),
    .periph_init(periph_init), .periph_reset(periph_reset),
    .periph_clk_en(periph_clk_en), .periph_wr_gated(periph_wr_gated),
    .periph_rdata_gated(periph_rdata_gated));
  gated_periph_model model (.clk_sys(clk_sys), .periph_reset(periph_reset),
    .periph_clk_en(periph_clk_en), .periph_wr_gated(periph_wr_gated), .wdata(wdata),
    .periph_rdata(periph_rdata), .periph_init(periph_init));

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // watchdog: the run needs well under 1500 cycles
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  function automatic int rix(int g);
    return (g < 5) ? 0 : (g == 5) ? 1 : (g < 12) ? 2 : 3;
  endfunction
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_vec(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one-cycle bus write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // one-cycle bus read; data looked at only in the following cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk_byte("reg_rdata", e, reg_rdata);
  endtask
  // one-cycle write strobe towards peripheral g, settled after the edge
  task automatic pwr(input int g);
    @(posedge clk_sys);
    periph_wr <= 16'h0001 << g;
    @(posedge clk_sys);
    periph_wr <= 16'h0000;
    #1;
  endtask

  // every register cleared, every peripheral running after reset
  task automatic test_reset_values;
    for (int r = 0; r < 4; r++) rd(ra[r], 8'h00);
    chk_vec("periph_reset", 16'h0000, periph_reset);
  endtask
  // each gate alone: reset, clock, write block, read substitution, release
  task automatic test_each_gate;
    logic [15:0] m;
    logic [7:0]  v;
    for (int g = 0; g < 16; g++) begin
      m = 16'h0001 << g;
      v = 8'h01 << bpos[g];
      wdata <= 8'h50 + 8'(g);
      wr(ra[rix(g)], v);
      rd(ra[rix(g)], v);
      chk_vec("periph_reset", m, periph_reset);
      chk_vec("periph_clk_en", ~m, periph_clk_en);
      pwr(g);
      chk_vec("periph_wr_gated", 16'h0000, periph_wr_gated);
      repeat (2) @(posedge clk_sys);
      #1 chk_byte("rdata_gated", 8'hA0 + 8'(g), periph_rdata_gated[8*g +: 8]);
      wr(ra[rix(g)], 8'h00);
      rd(ra[rix(g)], 8'h00);
      chk_vec("periph_reset", 16'h0000, periph_reset);
      pwr(g);
      chk_vec("periph_wr_gated", m, periph_wr_gated);
      repeat (2) @(posedge clk_sys);
      #1 chk_byte("rdata_gated", 8'h50 + 8'(g), periph_rdata_gated[8*g +: 8]);
    end
  endtask
  // spare bits and an unmapped address touch no peripheral
  task automatic test_spare_bits;
    for (int r = 0; r < 4; r++) begin
      wr(ra[r], spare[r]);
      rd(ra[r], spare[r]);
      chk_vec("periph_reset", 16'h0000, periph_reset);
      wr(ra[r], 8'h00);
    end
    wr(16'hF02B, 8'hFF);
    rd(16'hF02B, 8'h00);
    chk_vec("periph_reset", 16'h0000, periph_reset);
  endtask
  // write then read with no gap; read data stands one cycle only
  task automatic test_back_to_back;
    @(posedge clk_sys);
    reg_addr <= block_gating_pkg::TIMER_DISABLE_ADDR;
    reg_wdata <= 8'hC3;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk_byte("reg_rdata", 8'hC3, reg_rdata);
    @(posedge clk_sys);
    #1 chk_byte("reg_rdata idle", 8'h00, reg_rdata);
    chk_vec("periph_reset", 16'h0CC0, periph_reset);
    wr(block_gating_pkg::TIMER_DISABLE_ADDR, 8'h00);
  endtask
  // all gates shut, then a reset in mid-run clears everything
  task automatic test_midrun_reset;
    for (int r = 0; r < 4; r++) wr(ra[r], 8'hFF);
    @(posedge clk_sys);
    #1 chk_vec("periph_reset", 16'hFFFF, periph_reset);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    for (int r = 0; r < 4; r++) rd(ra[r], 8'h00);
    chk_vec("periph_clk_en", 16'hFFFF, periph_clk_en);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    n_errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    periph_wr = 16'h0000;
    wdata = 8'h00;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    test_reset_values();
    test_each_gate();
    test_spare_bits();
    test_back_to_back();
    test_midrun_reset();
    report_and_stop();
  end
endmodule // peripheral_block_gating_bench
